// ### hw/hwc_top.sv
`timescale 1ns/10ps
`include "hwc_map.svh"
// Function
// R1 - ready bit 27, read-only, set once stable
// R2 - ready set means host may access
// R3 - rising ready raises ready status event
// R4 - host reads only safe registers while not ready
// R5 - writes ignored until ready is set
// R6 - ready mirrors power management bit 0
// R7 - readable anytime, partial byte reads allowed
// R8 - host distrusts data while interface in reset
// R9 - bits 26/25 disable crossover, force straight
// R10 - bits 24/23 select fixed 100 full duplex
// R11 - negotiation off: link engine enforces fixed link
// R12 - negotiation off: enhanced detect resets PHY
// R13 - both engines off: PHY registers set mode
// R14 - crossover and negotiation defaults from straps
// R15 - polarity bit 0 low-active, 1 high-active
// R16 - bits 0-2 link LEDs, 3 run, 4 error
// R17 - polarity reset value is inverted strap
// R18 - polarity leaves sampled strap values untouched
// R19 - reserved bits read zero, writes ignored
module hwc_top
   import hwc_pkg::*;
(
   // clock and reset
   input wire logic MCLK,
   input wire logic RST_B,
   // readiness sources
   input wire logic DEV_STABLE,
   input wire logic HOLD_OFF,
   // host register port
   input wire logic HOST_CS,
   input wire logic HOST_RD,
   input wire logic HOST_WR,
   input wire logic [`HWC_AW-1:0] HOST_ADDR,
   input wire logic [3:0] HOST_BE,
   input wire logic [31:0] HOST_WDATA,
   output logic [31:0] HOST_RDATA,
   output logic HOST_ACK,
   // readiness outputs
   output logic DEV_READY,
   output logic PMT_READY,
   output logic READY_EVENT,
   // configuration straps, pins
   input wire logic STRAP_FD_A,
   input wire logic STRAP_FD_B,
   input wire logic [4:0] STRAP_LED_POL,
   output logic [4:0] STRAP_LED_POL_HELD,
   // phy mode controls
   output logic MDIX_DIS_A,
   output logic MDIX_DIS_B,
   output logic FIXED_FIXED_FULL_DUPLEX_STRAP_A,
   output logic FIXED_FIXED_FULL_DUPLEX_STRAP_B,
   // link detection engines
   input wire logic MI_DET_EN_A,
   input wire logic MI_DET_EN_B,
   input wire logic ELD_EN_A,
   input wire logic ELD_EN_B,
   output logic MI_ENFORCE_A,
   output logic MI_ENFORCE_B,
   output logic ELD_PHY_RST_A,
   output logic ELD_PHY_RST_B,
   output logic PHY_REG_MODE_A,
   output logic PHY_REG_MODE_B,
   // led activity in, pins out
   input wire logic [4:0] LED_ON,
   output logic [4:0] LED_PIN
);
   hwc_rdy_if rdy ();

   hwc_state_t state;
   hwc_state_t next_state;
   hwc_cnt_t settle;
   logic fd_a_meta;
   logic fd_a_sync;
   logic fd_b_meta;
   logic fd_b_sync;
   hwc_led_t pol_meta;
   hwc_led_t pol_sync;
   logic mdix_a;
   logic mdix_b;
   logic aneg_a;
   logic aneg_b;
   hwc_led_t led_pol;
   logic hit;
   logic wr_ok;
   logic load_straps;
   logic [31:0] rd_word;

   // level as driven on the pin for one LED
   function automatic logic led_level(input logic on,
                                      input logic pol);
      led_level = pol ? on : ~on; // R15
   endfunction : led_level

   // address match, alias window included
   function automatic logic addr_hit(
      input logic [`HWC_AW-1:0] a);
      addr_hit = (a == `HWC_CFG_ADDR) ||
                 (a == `HWC_CFG_ADDR_ALT);
   endfunction : addr_hit

   // one byte lane of an accepted write
   function automatic logic lane_wr(input logic ok,
                                    input logic [3:0] be,
                                    input int lane);
      lane_wr = ok & be[lane];
   endfunction : lane_wr

   assign rdy.hold_off = HOLD_OFF;

   hwc_ready_trk u_trk (
      .mclk(MCLK),
      .rst_b(RST_B),
      .dev_stable(DEV_STABLE),
      .rdy(rdy)
   );

   // strap pins come from outside the clock domain
   always_ff @(posedge MCLK or negedge RST_B) begin
      if (!RST_B) begin
         fd_a_meta <= 1'b0;
         fd_a_sync <= 1'b0;
         fd_b_meta <= 1'b0;
         fd_b_sync <= 1'b0;
         pol_meta <= `HWC_LED_RST;
         pol_sync <= `HWC_LED_RST;
      end else begin
         fd_a_meta <= STRAP_FD_A;
         fd_a_sync <= fd_a_meta;
         fd_b_meta <= STRAP_FD_B;
         fd_b_sync <= fd_b_meta;
         pol_meta <= STRAP_LED_POL;
         pol_sync <= pol_meta;
      end
   end

   // straps are caught after release, once the syncs have filled
   always_comb begin
      next_state = state;
      case (state)
         HWC_ST_RESET: begin
            next_state = HWC_ST_SETTLE;
         end
         HWC_ST_SETTLE: begin
            if (settle == `HWC_CNT_ZERO) begin
               next_state = HWC_ST_RUN;
            end
         end
         HWC_ST_RUN: begin
            next_state = HWC_ST_RUN;
         end
         default: begin
            next_state = HWC_ST_RESET;
         end
      endcase
   end

   always_ff @(posedge MCLK or negedge RST_B) begin
      if (!RST_B) begin
         state <= HWC_ST_RESET;
      end else begin
         state <= next_state;
      end
   end

   always_ff @(posedge MCLK or negedge RST_B) begin
      if (!RST_B) begin
         settle <= `HWC_SETTLE_CYC;
      end else if (state == HWC_ST_SETTLE &&
                   settle != `HWC_CNT_ZERO) begin
         settle <= settle - `HWC_CNT_ONE;
      end
   end

   assign load_straps = (state == HWC_ST_SETTLE) &&
                        (settle == `HWC_CNT_ZERO);

   // decode
   assign hit = HOST_CS & addr_hit(HOST_ADDR);
   // no write lands before ready, nor before straps are in
   assign wr_ok = hit & HOST_WR & rdy.ready &
                  (state == HWC_ST_RUN); // R5

   // crossover disables, defaults from fixed-link straps
   always_ff @(posedge MCLK or negedge RST_B) begin
      if (!RST_B) begin
         mdix_a <= 1'b0;
         mdix_b <= 1'b0;
      end else if (load_straps) begin
         mdix_a <= fd_a_sync; // R14
         mdix_b <= fd_b_sync; // R14
      end else if (lane_wr(wr_ok, HOST_BE, `HWC_BE_TOP)) begin
         mdix_a <= HOST_WDATA[`HWC_BIT_MDIX_A]; // R9
         mdix_b <= HOST_WDATA[`HWC_BIT_MDIX_B]; // R9
      end
   end

   // negotiation disables; bit 23 sits in byte lane 2
   always_ff @(posedge MCLK or negedge RST_B) begin
      if (!RST_B) begin
         aneg_a <= 1'b0;
      end else if (load_straps) begin
         aneg_a <= fd_a_sync; // R14
      end else if (lane_wr(wr_ok, HOST_BE, `HWC_BE_ANEG_A)) begin
         aneg_a <= HOST_WDATA[`HWC_BIT_ANEG_A]; // R10
      end
   end

   always_ff @(posedge MCLK or negedge RST_B) begin
      if (!RST_B) begin
         aneg_b <= 1'b0;
      end else if (load_straps) begin
         aneg_b <= fd_b_sync; // R14
      end else if (lane_wr(wr_ok, HOST_BE, `HWC_BE_TOP)) begin
         aneg_b <= HOST_WDATA[`HWC_BIT_ANEG_B]; // R10
      end
   end

   // led polarity, default is the strap turned round
   always_ff @(posedge MCLK or negedge RST_B) begin
      if (!RST_B) begin
         led_pol <= `HWC_LED_RST;
      end else if (load_straps) begin
         led_pol <= ~pol_sync; // R17
      end else if (lane_wr(wr_ok, HOST_BE, `HWC_BE_LED)) begin
         led_pol <= HOST_WDATA[`HWC_LED_HI:`HWC_LED_LO];
      end
   end

   // strap copy kept apart so polarity writes never reach it
   always_ff @(posedge MCLK or negedge RST_B) begin
      if (!RST_B) begin
         STRAP_LED_POL_HELD <= `HWC_LED_RST;
      end else if (load_straps) begin
         STRAP_LED_POL_HELD <= pol_sync; // R18
      end
   end

   // register image; reserved bits are tied low, never stored
   always_comb begin
      rd_word = `HWC_ZERO32; // R19
      rd_word[`HWC_BIT_READY] = rdy.ready; // R1
      rd_word[`HWC_BIT_MDIX_B] = mdix_b; // R9
      rd_word[`HWC_BIT_MDIX_A] = mdix_a; // R9
      rd_word[`HWC_BIT_ANEG_B] = aneg_b; // R10
      rd_word[`HWC_BIT_ANEG_A] = aneg_a; // R10
      rd_word[`HWC_LED_HI:`HWC_LED_LO] = led_pol; // R15
   end

   // register reads answer in any state, whole word every time
   always_ff @(posedge MCLK or negedge RST_B) begin
      if (!RST_B) begin
         HOST_RDATA <= `HWC_ZERO32;
      end else if (HOST_CS && HOST_RD) begin
         if (hit) begin
            HOST_RDATA <= rd_word; // R7
         end else begin
            HOST_RDATA <= `HWC_ZERO32; // R19
         end
      end
   end

   // every strobe is answered, refused writes included
   always_ff @(posedge MCLK or negedge RST_B) begin
      if (!RST_B) begin
         HOST_ACK <= 1'b0;
      end else begin
         HOST_ACK <= HOST_CS & (HOST_RD | HOST_WR); // R7
      end
   end

   // ready and its power management copy share one source
   always_ff @(posedge MCLK or negedge RST_B) begin
      if (!RST_B) begin
         DEV_READY <= 1'b0;
         PMT_READY <= 1'b0;
      end else begin
         DEV_READY <= rdy.ready; // R2
         PMT_READY <= rdy.ready; // R6
      end
   end

   always_ff @(posedge MCLK or negedge RST_B) begin
      if (!RST_B) begin
         READY_EVENT <= 1'b0;
      end else begin
         READY_EVENT <= rdy.ready_rise; // R3
      end
   end

   // phy mode pins
   always_ff @(posedge MCLK or negedge RST_B) begin
      if (!RST_B) begin
         MDIX_DIS_A <= 1'b0;
         MDIX_DIS_B <= 1'b0;
         FIXED_FIXED_FULL_DUPLEX_STRAP_A <= 1'b0;
         FIXED_FIXED_FULL_DUPLEX_STRAP_B <= 1'b0;
      end else begin
         MDIX_DIS_A <= mdix_a; // R9
         MDIX_DIS_B <= mdix_b; // R9
         FIXED_FIXED_FULL_DUPLEX_STRAP_A <= aneg_a; // R10
         FIXED_FIXED_FULL_DUPLEX_STRAP_B <= aneg_b; // R10
      end
   end

   // link engine steering
   always_ff @(posedge MCLK or negedge RST_B) begin
      if (!RST_B) begin
         MI_ENFORCE_A <= 1'b0;
         MI_ENFORCE_B <= 1'b0;
         ELD_PHY_RST_A <= 1'b0;
         ELD_PHY_RST_B <= 1'b0;
      end else begin
         MI_ENFORCE_A <= aneg_a & MI_DET_EN_A; // R11
         MI_ENFORCE_B <= aneg_b & MI_DET_EN_B; // R11
         ELD_PHY_RST_A <= aneg_a & ELD_EN_A; // R12
         ELD_PHY_RST_B <= aneg_b & ELD_EN_B; // R12
      end
   end

   // with both engines idle software owns the phy mode
   always_ff @(posedge MCLK or negedge RST_B) begin
      if (!RST_B) begin
         PHY_REG_MODE_A <= 1'b1;
         PHY_REG_MODE_B <= 1'b1;
      end else begin
         PHY_REG_MODE_A <= ~MI_DET_EN_A & ~ELD_EN_A; // R13
         PHY_REG_MODE_B <= ~MI_DET_EN_B & ~ELD_EN_B; // R13
      end
   end

   // led pins: 0-2 link, 3 run, 4 error
   always_ff @(posedge MCLK or negedge RST_B) begin
      if (!RST_B) begin
         LED_PIN <= `HWC_LED_RST;
      end else begin
         for (int i = 0; i <= `HWC_LED_HI; i++) begin
            LED_PIN[i] <= led_level(LED_ON[i], led_pol[i]); // R16
         end
      end
   end
endmodule : hwc_top

// ### pkg/hwc_map.svh
`ifndef HWC_MAP_SVH
`define HWC_MAP_SVH
`define HWC_AW 14
`define HWC_CFG_ADDR 14'h0074
`define HWC_CFG_ADDR_ALT 14'h3074
`define HWC_BIT_READY 27
`define HWC_BIT_MDIX_B 26
`define HWC_BIT_MDIX_A 25
`define HWC_BIT_ANEG_B 24
`define HWC_BIT_ANEG_A 23
`define HWC_LED_HI 4
`define HWC_LED_LO 0
`define HWC_BE_LED 0
`define HWC_BE_ANEG_A 2
`define HWC_BE_TOP 3
`define HWC_LED_RST 5'h00
`define HWC_ZERO32 32'h00000000
`define HWC_SETTLE_CYC 2'h2
`define HWC_CNT_ONE 2'h1
`define HWC_CNT_ZERO 2'h0
`endif

// ### pkg/hwc_pkg.sv
package hwc_pkg;
   typedef enum logic [2:0] {
      HWC_ST_RESET = 3'b001,
      HWC_ST_SETTLE = 3'b010,
      HWC_ST_RUN = 3'b100
   } hwc_state_t;
   typedef logic [4:0] hwc_led_t;
   typedef logic [1:0] hwc_cnt_t;
endpackage : hwc_pkg

// ### pkg/hwc_rdy_if.sv
`timescale 1ns/10ps
interface hwc_rdy_if;
   logic ready;
   logic ready_rise;
   logic hold_off;
   modport src (
      output ready,
      output ready_rise,
      input hold_off
   );
   modport dst (
      input ready,
      input ready_rise,
      output hold_off
   );
endinterface : hwc_rdy_if

// ### hw/hwc_ready_trk.sv
`timescale 1ns/10ps
module hwc_ready_trk
   import hwc_pkg::*;
(
   // clock and reset
   input wire logic mclk,
   input wire logic rst_b,
   // stabilised indication from the device core, a pin
   input wire logic dev_stable,
   // readiness to the register block
   hwc_rdy_if.src rdy
);
   logic stable_meta;
   logic stable_sync;
   logic next_ready;

   // plain two-stage synchroniser, first stage read only by second
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         stable_meta <= 1'b0;
         stable_sync <= 1'b0;
      end else begin
         stable_meta <= dev_stable;
         stable_sync <= stable_meta;
      end
   end

   // any reset source or power-saving state drops readiness
   assign next_ready = stable_sync & ~rdy.hold_off; // R1

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         rdy.ready <= 1'b0; // R1
      end else begin
         rdy.ready <= next_ready;
      end
   end

   // event on each low-to-high step only
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         rdy.ready_rise <= 1'b0;
      end else begin
         rdy.ready_rise <= next_ready & ~rdy.ready; // R3
      end
   end
endmodule : hwc_ready_trk

// ### bench/hwc_top_asserts.sv
`timescale 1ns/10ps
module hwc_top_asserts (
   // clock, reset
   input wire logic MCLK,
   input wire logic RST_B,
   // watched
   input wire logic DEV_STABLE,
   input wire logic HOLD_OFF,
   input wire logic HOST_CS,
   input wire logic HOST_RD,
   input wire logic HOST_WR,
   input wire logic MI_DET_EN_A,
   input wire logic ELD_EN_A,
   input wire logic [31:0] HOST_RDATA,
   input wire logic HOST_ACK,
   input wire logic DEV_READY,
   input wire logic PMT_READY,
   input wire logic READY_EVENT,
   input wire logic FIXED_FIXED_FULL_DUPLEX_STRAP_A,
   input wire logic MI_ENFORCE_A,
   input wire logic ELD_PHY_RST_A,
   input wire logic PHY_REG_MODE_A
);
   default clocking cb @(posedge MCLK);
   endclocking
   default disable iff (!RST_B);
   wire req = HOST_CS && (HOST_RD || HOST_WR);
   a_pmt_mirror: assert property (PMT_READY == DEV_READY)
      else $error("pmt bit differs");
   a_event_rise: assert property ($rose(DEV_READY) |-> READY_EVENT)
      else $error("no ready event");
   a_event_only: assert property (READY_EVENT |->
      $rose(DEV_READY) ##1 !READY_EVENT)
      else $error("stray ready event");
   a_ack_next: assert property (req |=> HOST_ACK)
      else $error("missing ack");
   a_ack_only: assert property (!req |=> !HOST_ACK)
      else $error("stray ack");
   // six samples cover the two sync flops and both ready flops
   a_stable_need: assert property (!DEV_STABLE [*6] |-> !DEV_READY)
      else $error("ready without stable core");
   a_hold_drop: assert property (HOLD_OFF |-> ##2 !DEV_READY)
      else $error("ready kept in hold off");
   a_mi_fixed: assert property ($past(RST_B) |-> MI_ENFORCE_A ==
      (FIXED_FIXED_FULL_DUPLEX_STRAP_A && $past(MI_DET_EN_A)))
      else $error("link enforce wrong");
   a_eld_reset: assert property ($past(RST_B) |-> ELD_PHY_RST_A ==
      (FIXED_FIXED_FULL_DUPLEX_STRAP_A && $past(ELD_EN_A)))
      else $error("enhanced reset wrong");
   a_phy_mode: assert property ($past(RST_B) |-> PHY_REG_MODE_A ==
      !$past(MI_DET_EN_A || ELD_EN_A))
      else $error("phy register mode wrong");
   a_rsvd_zero: assert property ($past(HOST_CS && HOST_RD)
      |-> HOST_RDATA[31:28] == 4'h0 && HOST_RDATA[22:5] == 18'h00000)
      else $error("reserved bits set");
   c_event: cover property (READY_EVENT);
   c_ready_read: cover property (HOST_ACK && HOST_RDATA[27]);
   c_enforce: cover property (MI_ENFORCE_A);
endmodule : hwc_top_asserts

bind hwc_top hwc_top_asserts i_hwc_top_asserts (.MCLK, .RST_B,
   .DEV_STABLE, .HOLD_OFF, .HOST_CS, .HOST_RD, .HOST_WR, .MI_DET_EN_A,
   .ELD_EN_A, .HOST_RDATA, .HOST_ACK, .DEV_READY, .PMT_READY,
   .READY_EVENT, .FIXED_FIXED_FULL_DUPLEX_STRAP_A, .MI_ENFORCE_A, .ELD_PHY_RST_A,
   .PHY_REG_MODE_A);

// ### bench/hwc_host_mdl.sv
`timescale 1ns/10ps
`include "hwc_map.svh"
module hwc_host_mdl (
   // clock, answer
   input wire logic clk,
   input wire logic [31:0] rdata,
   input wire logic ack,
   // request
   output logic cs,
   output logic rd,
   output logic wr,
   output logic [`HWC_AW-1:0] addr,
   output logic [3:0] be,
   output logic [31:0] wdata,
   output logic hung
);
   // idle while the interface is still in reset
   initial begin
      {cs, rd, wr, hung, be} = 8'h00;
      addr = 14'h0000;
      wdata = 32'h00000000;
   end
   // one read or write to any address, ready or not; waits up to 8 cycles for ack
   task automatic xfer(input logic w, input logic [`HWC_AW-1:0] a,
         input logic [3:0] b, input logic [31:0] d,
         output logic [31:0] q);
      int n;
      @(posedge clk);
      cs <= 1'b1;
      rd <= !w;
      wr <= w;
      addr <= a;
      be <= b;
      wdata <= d;
      @(posedge clk);
      // one-cycle strobe; released lines must not look valid
      cs <= 1'b0;
      rd <= 1'b0;
      wr <= 1'b0;
      addr <= ~a;
      wdata <= ~d;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (ack !== 1'b1 && n < 8);
      if (n >= 8) hung <= 1'b1;
      q = rdata;
   endtask : xfer
endmodule : hwc_host_mdl

// ### bench/testbench.sv
`timescale 1ns/10ps
`include "hwc_map.svh"
module testbench;
   logic mclk, rst_b, stable, hold, cs, rd, wr, ack, hung;
   logic fd_a, fd_b, mi_a, mi_b, eld_a, eld_b, rdy, pmt, evt;
   logic [`HWC_AW-1:0] addr;
   logic [3:0] be;
   logic [31:0] wdata, rdata, q;
   logic [4:0] pol_s, held, led_on, led_pin;
   wire [3:0] phy;
   wire [5:0] eng;
   int miscompares, checked;
   hwc_top i_hwc_top (.MCLK(mclk), .RST_B(rst_b), .DEV_STABLE(stable),
      .HOLD_OFF(hold), .HOST_CS(cs), .HOST_RD(rd), .HOST_WR(wr),
      .HOST_ADDR(addr), .HOST_BE(be), .HOST_WDATA(wdata),
      .HOST_RDATA(rdata), .HOST_ACK(ack), .DEV_READY(rdy),
      .PMT_READY(pmt), .READY_EVENT(evt), .STRAP_FD_A(fd_a),
      .STRAP_FD_B(fd_b), .STRAP_LED_POL(pol_s),
      .STRAP_LED_POL_HELD(held), .MDIX_DIS_A(phy[3]),
      .MDIX_DIS_B(phy[2]), .FIXED_FIXED_FULL_DUPLEX_STRAP_A(phy[1]),
      .FIXED_FIXED_FULL_DUPLEX_STRAP_B(phy[0]), .MI_DET_EN_A(mi_a), .MI_DET_EN_B(mi_b),
      .ELD_EN_A(eld_a), .ELD_EN_B(eld_b), .MI_ENFORCE_A(eng[5]),
      .MI_ENFORCE_B(eng[4]), .ELD_PHY_RST_A(eng[3]),
      .ELD_PHY_RST_B(eng[2]), .PHY_REG_MODE_A(eng[1]),
      .PHY_REG_MODE_B(eng[0]), .LED_ON(led_on), .LED_PIN(led_pin));
   hwc_host_mdl i_hwc_host_mdl (.clk(mclk), .rdata(rdata), .ack(ack),
      .cs(cs), .rd(rd), .wr(wr), .addr(addr), .be(be), .wdata(wdata),
      .hung(hung));
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         miscompares++;
         $display("MISMATCH %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic conclude;
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : conclude
   always @(posedge hung) begin
      miscompares++;
      conclude();
   end
   task automatic cyc(input int n);
      repeat (n) @(posedge mclk);
   endtask : cyc
   task automatic rdc(input logic [13:0] a, input logic [31:0] e);
      i_hwc_host_mdl.xfer(1'b0, a, 4'h0, 32'h00000000, q);
      chk(q, e);
   endtask : rdc
   task automatic wrr(input logic [3:0] b, input logic [31:0] d);
      i_hwc_host_mdl.xfer(1'b1, `HWC_CFG_ADDR, b, d, q);
   endtask : wrr
   // bounded, a stuck ready ends the run
   task automatic wait_rdy;
      int n;
      n = 0;
      while (rdy !== 1'b1 && n < 20) begin
         @(posedge mclk);
         n++;
      end
      if (n >= 20) begin
         miscompares++;
         conclude();
      end
   endtask : wait_rdy
   task automatic t_reset;
      cyc(5);
      rdc(`HWC_CFG_ADDR, 32'h02800015);
      rdc(`HWC_CFG_ADDR_ALT, 32'h02800015);
      rdc(14'h0064, 32'h00000000);
      wrr(4'hF, 32'hFFFFFFFF);
      rdc(`HWC_CFG_ADDR, 32'h02800015);
      chk({phy, held}, {4'hA, 5'h0A});
      $display("test reset done");
   endtask : t_reset
   task automatic t_ready;
      @(posedge mclk) stable <= 1'b1;
      wait_rdy();
      chk({evt, pmt}, 2'h3);
      cyc(1);
      chk(evt, 1'b0);
      rdc(`HWC_CFG_ADDR, 32'h0A800015);
      $display("test ready done");
   endtask : t_ready
   task automatic t_write;
      wrr(4'hF, 32'hFFFFFFFF);
      rdc(`HWC_CFG_ADDR, 32'h0F80001F);
      chk(phy, 4'hF);
      wrr(4'h1, 32'h00000000);
      wrr(4'h8, 32'h00000000);
      rdc(`HWC_CFG_ADDR, 32'h08800000);
      chk(phy, 4'h2);
      $display("test write done");
   endtask : t_write
   task automatic t_led;
      logic [4:0] pols [3] = '{5'h00, 5'h1F, 5'h0A};
      logic [4:0] e;
      foreach (pols[i]) begin
         wrr(4'h1, {27'h0, pols[i]});
         @(posedge mclk) led_on <= pols[i] ^ 5'h05;
         cyc(3);
         e = ~(led_on ^ pols[i]);
         chk(led_pin, e);
         chk(held, 5'h0A);
      end
      $display("test led done");
   endtask : t_led
   // order: link enforce a b, enhanced reset a b, phy mode a b
   task automatic eng_set(input logic [3:0] v, input logic [5:0] e);
      @(posedge mclk) {mi_a, mi_b, eld_a, eld_b} <= v;
      cyc(3);
      chk(eng, e);
   endtask : eng_set
   task automatic t_engines;
      eng_set(4'hE, 6'h28);
      wrr(4'h8, 32'h01000000);
      wrr(4'h4, 32'h00000000);
      eng_set(4'h5, 6'h16);
      eng_set(4'h0, 6'h03);
      $display("test engines done");
   endtask : t_engines
   task automatic t_holdoff;
      @(posedge mclk) hold <= 1'b1;
      cyc(4);
      chk({rdy, pmt}, 2'h0);
      hold <= 1'b0;
      wait_rdy();
      chk(evt, 1'b1);
      $display("test holdoff done");
   endtask : t_holdoff
   // pin reset mid-run: ready drops, comes back, straps reload
   task automatic t_rerun;
      @(posedge mclk) rst_b <= 1'b0;
      cyc(2);
      chk({rdy, pmt, evt}, 3'h0);
      rst_b <= 1'b1;
      wait_rdy();
      chk(evt, 1'b1);
      rdc(`HWC_CFG_ADDR, 32'h0A800015);
      $display("test rerun done");
   endtask : t_rerun
   initial begin
      {rst_b, stable, hold, fd_b, mi_a, mi_b, eld_a, eld_b} = 8'h00;
      fd_a = 1'b1;
      pol_s = 5'h0A;
      led_on = 5'h05;
      miscompares = 0;
      checked = 0;
      cyc(5);
      rst_b <= 1'b1;
      t_reset();
      t_ready();
      t_write();
      t_led();
      t_engines();
      t_holdoff();
      t_rerun();
      conclude();
   end
endmodule : testbench
